// file: src/maint_regs_pkg.sv
// constants, field layouts and carriers for the maintenance and interrupt mask register bank
package maint_regs_pkg;
    localparam int num_channels = 2;
    localparam int addr_width = 8;
    localparam int data_width = 8;
    localparam int count_width = 16;

    // channel copies sit 20 hex apart; bit 5 of the address picks the channel
    localparam int chan_addr_bit = 5;
    localparam logic [4:0] off_deact_len = 5'h0f;
    localparam logic [4:0] off_deact_pattern = 5'h11;
    localparam logic [4:0] off_ctrl = 5'h12;
    localparam logic [4:0] off_mask_line = 5'h13;
    localparam logic [4:0] off_mask_error = 5'h14;
    localparam logic [4:0] off_edge_sel = 5'h15;
    localparam logic [4:0] off_flag_line = 5'h18;
    localparam logic [4:0] off_flag_error = 5'h19;
    localparam logic [4:0] off_count_low = 5'h1a;
    localparam logic [4:0] off_count_high = 5'h1b;

    localparam logic [7:0] deact_pattern_reset = 8'h09;
    localparam logic [1:0] deact_len_reset = 2'h1;
    localparam logic [7:0] mask_reset = 8'hff;
    localparam logic [7:0] edge_sel_reset = 8'h00;
    localparam logic [7:0] flag_reset = 8'h00;

    // error event group positions driven from inside the block
    localparam int err_bit_count_overflow = 0;
    localparam int err_bit_second_tick = 1;

    typedef enum logic [1:0] {
        sel_pattern = 2'b00,
        sel_excess_zero = 2'b01,
        sel_code_violation = 2'b10,
        sel_cv_and_exz = 2'b11
    } count_sel_type;

    // bit 7 down to bit 0 of the control register
    typedef struct packed {
        logic reserved;
        logic violation_inject;
        logic pattern_error_inject;
        logic excess_zero_rule_sel;
        count_sel_type error_sel;
        logic count_report_mode;
        logic count_transfer;
    } ctrl_type;

    localparam ctrl_type ctrl_reset = '{1'b0, 1'b0, 1'b0, 1'b0, sel_pattern, 1'b0, 1'b0};

    // one-cycle error pulses from the receive detectors of a channel
    typedef struct packed {
        logic pattern_error;
        logic excess_zero_ansi;
        logic excess_zero_fcc;
        logic code_violation;
    } err_in_type;
endpackage

// file: src/maint_error_count_irq_mask_regs.sv
// per-channel maintenance, error counter and interrupt mask registers of the line interface
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module maint_error_count_irq_mask_regs
    import maint_regs_pkg::*;
#(
    parameter int cnt_width = count_width
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [addr_width-1:0] addr,
    input wire logic [data_width-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [data_width-1:0] rd_data,
    input wire logic [num_channels-1:0][7:0] line_status,
    input wire logic [num_channels-1:0][7:0] error_events,
    input wire err_in_type [num_channels-1:0] err_in,
    input wire logic second_tick,
    output logic [num_channels-1:0][7:0] rx_deact_pattern,
    output logic [num_channels-1:0][1:0] rx_deact_pattern_len,
    output logic [num_channels-1:0] violation_inject,
    output logic [num_channels-1:0] pattern_error_inject,
    output logic irq
);

    // true when the address names register off of channel ch
    function automatic logic reg_hit(input logic [addr_width-1:0] a, input int ch,
                                     input logic [4:0] off);
        reg_hit = (a[4:0] == off) && (a[chan_addr_bit] == ch[0])
            && (a[addr_width-1:chan_addr_bit+1] == '0);
    endfunction

    // an event is a rising edge, or any change when edge select is set
    function automatic logic [7:0] event_detect(input logic [7:0] prev, input logic [7:0] cur,
                                                input logic [7:0] any_edge);
        event_detect = (cur & ~prev) | (any_edge & (cur ^ prev));
    endfunction

    logic [num_channels-1:0][7:0] pattern, next_pattern;
    logic [num_channels-1:0][1:0] pat_len, next_pat_len;
    ctrl_type [num_channels-1:0] ctrl, next_ctrl;
    ctrl_type [num_channels-1:0] ctrl_prev, next_ctrl_prev;
    logic [num_channels-1:0][7:0] mask_line, next_mask_line;
    logic [num_channels-1:0][7:0] mask_error, next_mask_error;
    logic [num_channels-1:0][7:0] edge_sel, next_edge_sel;
    logic [num_channels-1:0][7:0] flag_line, next_flag_line;
    logic [num_channels-1:0][7:0] flag_error, next_flag_error;
    logic [num_channels-1:0][7:0] prev_line, next_prev_line;
    logic [num_channels-1:0][7:0] prev_error, next_prev_error;
    logic [num_channels-1:0][cnt_width-1:0] counter, next_counter;
    logic [num_channels-1:0][cnt_width-1:0] result, next_result;
    logic [num_channels-1:0] next_violation_inject, next_pattern_error_inject;
    logic [data_width-1:0] next_rd_data;
    logic next_irq;

    // configuration, injection, error counter and interrupt flag group
    always_comb begin
        logic [7:0] line_ev;
        logic [7:0] err_ev;
        logic [7:0] err_now;
        logic inc;
        logic exz;
        logic transfer;
        logic overflow;
        line_ev = '0;
        err_ev = '0;
        err_now = '0;
        inc = 1'b0;
        exz = 1'b0;
        transfer = 1'b0;
        overflow = 1'b0;
        next_irq = 1'b0;
        for (int ch = 0; ch < num_channels; ch++) begin
            next_pattern[ch] = pattern[ch];
            next_pat_len[ch] = pat_len[ch];
            next_ctrl[ch] = ctrl[ch];
            next_mask_line[ch] = mask_line[ch];
            next_mask_error[ch] = mask_error[ch];
            next_edge_sel[ch] = edge_sel[ch];
            next_ctrl_prev[ch] = ctrl[ch];
            next_violation_inject[ch] = ctrl[ch].violation_inject
                & ~ctrl_prev[ch].violation_inject;
            next_pattern_error_inject[ch] = ctrl[ch].pattern_error_inject
                & ~ctrl_prev[ch].pattern_error_inject;

            // error counter; counting and transfer in one cycle keeps that error
            exz = ctrl[ch].excess_zero_rule_sel ? err_in[ch].excess_zero_fcc
                : err_in[ch].excess_zero_ansi;
            case (ctrl[ch].error_sel)
                sel_pattern: inc = err_in[ch].pattern_error;
                sel_excess_zero: inc = exz;
                sel_code_violation: inc = err_in[ch].code_violation;
                sel_cv_and_exz: inc = err_in[ch].code_violation | exz;
                default: inc = 1'b0;
            endcase
            if (ctrl[ch].count_report_mode) begin
                transfer = second_tick;
            end else begin
                // a held transfer bit gives one transfer only
                transfer = ctrl[ch].count_transfer & ~ctrl_prev[ch].count_transfer;
            end
            overflow = inc & (&counter[ch]) & ~transfer;
            next_result[ch] = transfer ? counter[ch] : result[ch];
            next_counter[ch] = transfer ? cnt_width'(inc) : counter[ch] + cnt_width'(inc);

            // sticky flags; a new event beats a write-one clear in the same cycle
            err_now = error_events[ch];
            err_now[err_bit_second_tick] = err_now[err_bit_second_tick] | second_tick;
            err_now[err_bit_count_overflow] = err_now[err_bit_count_overflow] | overflow;
            line_ev = event_detect(prev_line[ch], line_status[ch], edge_sel[ch]);
            err_ev = event_detect(prev_error[ch], err_now, 8'h00);
            next_prev_line[ch] = line_status[ch];
            next_prev_error[ch] = err_now;
            next_flag_line[ch] = flag_line[ch];
            next_flag_error[ch] = flag_error[ch];

            if (wr_en) begin
                if (reg_hit(addr, ch, off_deact_pattern)) begin
                    next_pattern[ch] = wr_data;
                end
                if (reg_hit(addr, ch, off_deact_len)) begin
                    next_pat_len[ch] = wr_data[1:0];
                end
                if (reg_hit(addr, ch, off_ctrl)) begin
                    next_ctrl[ch] = ctrl_type'(wr_data);
                    next_ctrl[ch].reserved = 1'b0;
                end
                if (reg_hit(addr, ch, off_mask_line)) begin
                    next_mask_line[ch] = wr_data;
                end
                if (reg_hit(addr, ch, off_mask_error)) begin
                    next_mask_error[ch] = wr_data;
                end
                if (reg_hit(addr, ch, off_edge_sel)) begin
                    next_edge_sel[ch] = wr_data;
                end
                if (reg_hit(addr, ch, off_flag_line)) begin
                    next_flag_line[ch] = flag_line[ch] & ~wr_data;
                end
                if (reg_hit(addr, ch, off_flag_error)) begin
                    next_flag_error[ch] = flag_error[ch] & ~wr_data;
                end
            end
            next_flag_line[ch] = next_flag_line[ch] | line_ev;
            next_flag_error[ch] = next_flag_error[ch] | err_ev;
            next_irq = next_irq | (|(flag_line[ch] & ~mask_line[ch]))
                | (|(flag_error[ch] & ~mask_error[ch]));
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int ch = 0; ch < num_channels; ch++) begin
                pattern[ch] <= deact_pattern_reset;
                pat_len[ch] <= deact_len_reset;
                ctrl[ch] <= ctrl_reset;
                ctrl_prev[ch] <= ctrl_reset;
                mask_line[ch] <= mask_reset;
                mask_error[ch] <= mask_reset;
                edge_sel[ch] <= edge_sel_reset;
                flag_line[ch] <= flag_reset;
                flag_error[ch] <= flag_reset;
                prev_line[ch] <= flag_reset;
                prev_error[ch] <= flag_reset;
                counter[ch] <= '0;
                result[ch] <= '0;
            end
            violation_inject <= '0;
            pattern_error_inject <= '0;
            irq <= 1'b0;
        end else begin
            pattern <= next_pattern;
            pat_len <= next_pat_len;
            ctrl <= next_ctrl;
            ctrl_prev <= next_ctrl_prev;
            mask_line <= next_mask_line;
            mask_error <= next_mask_error;
            edge_sel <= next_edge_sel;
            flag_line <= next_flag_line;
            flag_error <= next_flag_error;
            prev_line <= next_prev_line;
            prev_error <= next_prev_error;
            counter <= next_counter;
            result <= next_result;
            violation_inject <= next_violation_inject;
            pattern_error_inject <= next_pattern_error_inject;
            irq <= next_irq;
        end
    end

    // register outputs of the pattern settings for the code detector
    always_comb begin
        rx_deact_pattern = pattern;
        rx_deact_pattern_len = pat_len;
    end

    // read port: data stand one cycle after the strobe, zero for unmapped addresses
    always_comb begin
        next_rd_data = '0;
        if (rd_en) begin
            for (int ch = 0; ch < num_channels; ch++) begin
                if (reg_hit(addr, ch, off_deact_pattern)) begin
                    next_rd_data = pattern[ch];
                end
                if (reg_hit(addr, ch, off_deact_len)) begin
                    next_rd_data = {6'h00, pat_len[ch]};
                end
                if (reg_hit(addr, ch, off_ctrl)) begin
                    next_rd_data = ctrl[ch];
                end
                if (reg_hit(addr, ch, off_mask_line)) begin
                    next_rd_data = mask_line[ch];
                end
                if (reg_hit(addr, ch, off_mask_error)) begin
                    next_rd_data = mask_error[ch];
                end
                if (reg_hit(addr, ch, off_edge_sel)) begin
                    next_rd_data = edge_sel[ch];
                end
                if (reg_hit(addr, ch, off_flag_line)) begin
                    next_rd_data = flag_line[ch];
                end
                if (reg_hit(addr, ch, off_flag_error)) begin
                    next_rd_data = flag_error[ch];
                end
                if (reg_hit(addr, ch, off_count_low)) begin
                    next_rd_data = result[ch][7:0];
                end
                if (reg_hit(addr, ch, off_count_high)) begin
                    next_rd_data = result[ch][15:8];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
    end
endmodule
`default_nettype wire

// file: bench/maint_regs_sva.sv
// assertion checker for the maintenance and interrupt mask register bank
`timescale 1ns/100ps
`default_nettype none
module maint_regs_sva
    import maint_regs_pkg::*;
#(
    parameter int cnt_width = count_width
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [addr_width-1:0] addr,
    input wire logic [data_width-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [data_width-1:0] rd_data,
    input wire logic [num_channels-1:0][7:0] line_status,
    input wire logic [num_channels-1:0][7:0] error_events,
    input wire err_in_type [num_channels-1:0] err_in,
    input wire logic second_tick,
    input wire logic [num_channels-1:0][7:0] rx_deact_pattern,
    input wire logic [num_channels-1:0][1:0] rx_deact_pattern_len,
    input wire logic [num_channels-1:0] violation_inject,
    input wire logic [num_channels-1:0] pattern_error_inject,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence pat_wr0;
        wr_en && addr == 8'h11;
    endsequence
    sequence vi_cause;
        $past(wr_en && addr == 8'h12 && wr_data[6], 2);
    endsequence
    // a stale read value would look like a second answer
    chk_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data not zero after an idle cycle");
    chk_pattern_wr: assert property (pat_wr0 |=> rx_deact_pattern[0] == $past(wr_data))
        else $error("channel 0 pattern did not take the write");
    chk_pattern_rd: assert property (rd_en && addr == 8'h31 |=> rd_data == rx_deact_pattern[1])
        else $error("channel 1 pattern read back wrong");
    chk_len_wr: assert property (wr_en && addr == 8'h2f |=> rx_deact_pattern_len[1] == $past(wr_data[1:0]))
        else $error("channel 1 length did not take the write");
    chk_reset_vals: assert property ($fell(rst) |-> rx_deact_pattern == {2{8'h09}} && rx_deact_pattern_len == {2{2'h1}} && !irq)
        else $error("wrong values after reset");
    chk_viol_once: assert property (violation_inject[0] |-> vi_cause ##1 !violation_inject[0])
        else $error("violation pulse without a fresh set or too long");
    chk_perr_once: assert property (pattern_error_inject[1] |-> $past(wr_en && addr == 8'h32 && wr_data[5], 2) ##1 !pattern_error_inject[1])
        else $error("pattern error pulse without a fresh set or too long");
    chk_irq_fall: assert property ($fell(irq) |-> $past(wr_en, 2))
        else $error("interrupt dropped without a software write");
    chk_irq_cause: assert property ($rose(irq) |-> $past(wr_en, 2) || $past(second_tick, 2) || $past(line_status, 2) != $past(line_status, 3) || $past(error_events, 2) != $past(error_events, 3) || |{$past(err_in, 2), $past(err_in, 3)})
        else $error("interrupt rose without an event");
endmodule
bind maint_error_count_irq_mask_regs maint_regs_sva #(.cnt_width(cnt_width)) sva (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .line_status(line_status), .error_events(error_events),
    .err_in(err_in), .second_tick(second_tick), .rx_deact_pattern(rx_deact_pattern),
    .rx_deact_pattern_len(rx_deact_pattern_len), .violation_inject(violation_inject),
    .pattern_error_inject(pattern_error_inject), .irq(irq));
`default_nettype wire

// file: bench/maint_error_count_irq_mask_regs_tb.sv
// self-checking bench for the maintenance and interrupt mask register bank
`timescale 1ns/100ps
`default_nettype none
module maint_error_count_irq_mask_regs_tb
    import maint_regs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic second_tick = 1'b0;
    logic [1:0][7:0] line_status = '0;
    logic [1:0][7:0] error_events = '0;
    err_in_type [1:0] err_in = '0;
    logic [7:0] rd_data;
    logic [1:0][7:0] rx_deact_pattern;
    logic [1:0][1:0] rx_deact_pattern_len;
    logic [1:0] violation_inject;
    logic [1:0] pattern_error_inject;
    logic irq;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_vi = 0;
    int n_pe = 0;
    maint_error_count_irq_mask_regs #(.cnt_width(16)) dut (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .line_status(line_status), .error_events(error_events),
        .err_in(err_in), .second_tick(second_tick), .rx_deact_pattern(rx_deact_pattern),
        .rx_deact_pattern_len(rx_deact_pattern_len), .violation_inject(violation_inject),
        .pattern_error_inject(pattern_error_inject), .irq(irq));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic give_verdict(input bit hang);
        if (hang)
            n_errors++;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // well past the roughly 330 cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        // both channels counted: a pulse on the channel never written shows as an extra count
        n_vi <= n_vi + violation_inject[0] + violation_inject[1];
        n_pe <= n_pe + pattern_error_inject[0] + pattern_error_inject[1];
        if (cycles == 4000)
            give_verdict(1'b1);
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // the idle cycle keeps a strobe from being lowered and raised in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 chk(what, exp, rd_data);
        @(posedge core_clk);
    endtask
    task automatic pulse_err(input int k, input int n);
        repeat (n) begin
            err_in[0] <= err_in_type'(4'h1 << k);
            @(posedge core_clk);
            err_in[0] <= '0;
            @(posedge core_clk);
        end
    endtask
    initial begin
        logic [7:0] exz;
        logic [7:0] exp;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int c = 0; c < 2; c++) begin
            rd({2'b00, c[0], 5'h11}, 8'h09, "pattern");
            rd({2'b00, c[0], 5'h0f}, 8'h01, "length");
            rd({2'b00, c[0], 5'h12}, 8'h00, "ctrl");
            rd({2'b00, c[0], 5'h13}, 8'hff, "line mask");
            rd({2'b00, c[0], 5'h14}, 8'hff, "error mask");
            rd({2'b00, c[0], 5'h16}, 8'h00, "unmapped");
        end
        $display("reset values test done");
        wr(8'h11, 8'ha5);
        for (int l = 0; l < 4; l++) begin
            wr(8'h2f, 8'(l));
            @(negedge core_clk);
            chk("length ch1", 8'(l), 8'(rx_deact_pattern_len[1]));
            @(posedge core_clk);
        end
        @(negedge core_clk);
        chk("pattern ch0", 8'ha5, rx_deact_pattern[0]);
        chk("pattern ch1", 8'h09, rx_deact_pattern[1]);
        @(posedge core_clk);
        $display("pattern test done");
        wr(8'h12, 8'h40);
        wr(8'h12, 8'h40);
        wr(8'h12, 8'h00);
        wr(8'h12, 8'h40);
        wr(8'h32, 8'h20);
        wr(8'h32, 8'h20);
        repeat (3) @(posedge core_clk);
        chk("violation pulses", 8'h02, 8'(n_vi));
        chk("pattern error pulses", 8'h01, 8'(n_pe));
        $display("inject test done");
        for (int s = 0; s < 8; s++) begin
            wr(8'h12, {3'b000, s[0], s[2:1], 2'b00});
            for (int k = 0; k < 4; k++)
                pulse_err(k, k + 1);
            wr(8'h12, {3'b000, s[0], s[2:1], 2'b01});
            exz = s[0] ? 8'h02 : 8'h03;
            exp = s[2:1] == 0 ? 8'h04 : s[2:1] == 1 ? exz : s[2:1] == 2 ? 8'h01 : exz + 8'h01;
            rd(8'h1a, exp, "count low");
            rd(8'h1b, 8'h00, "count high");
        end
        pulse_err(0, 1);
        wr(8'h12, 8'h1d);
        rd(8'h1a, 8'h03, "count held");
        wr(8'h12, 8'h0a);
        pulse_err(0, 1);
        second_tick <= 1'b1;
        @(posedge core_clk);
        second_tick <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(8'h1a, 8'h02, "auto count");
        $display("counter test done");
        wr(8'h13, 8'hfe);
        line_status[0] <= 8'h03;
        repeat (3) @(negedge core_clk);
        chk("irq line", 8'h01, 8'(irq));
        @(posedge core_clk);
        rd(8'h18, 8'h03, "line flags");
        wr(8'h18, 8'h01);
        @(negedge core_clk);
        chk("irq masked", 8'h00, 8'(irq));
        @(posedge core_clk);
        wr(8'h15, 8'h01);
        line_status[0] <= 8'h02;
        repeat (3) @(negedge core_clk);
        chk("irq any change", 8'h01, 8'(irq));
        @(posedge core_clk);
        wr(8'h18, 8'h03);
        wr(8'h34, 8'h7d);
        rd(8'h39, 8'h02, "error flags");
        error_events[1] <= 8'h80;
        repeat (3) @(posedge core_clk);
        rd(8'h39, 8'h82, "error flags");
        wr(8'h39, 8'h82);
        @(negedge core_clk);
        chk("irq cleared", 8'h00, 8'(irq));
        $display("interrupt test done");
        give_verdict(1'b0);
    end
endmodule
`default_nettype wire
